// ==== design/lslcr_pkg.sv ====
// Package with register map, field layout, reset values and lane modes for the lane config bank.
package lslcr_pkg;
    localparam int          DATA_W          = 16;
    localparam int          ADDR_W          = 16;
    localparam int          LANES           = 4;
    localparam logic [4:0]  DEV_ADDR        = 5'h1E;
    localparam logic [15:0] OFS_GLOBAL_CTRL = 16'h0001;
    localparam logic [15:0] OFS_LANE_CFG    = 16'h0007;
    localparam logic [15:0] OFS_POLARITY_EQ = 16'h0008;
    localparam logic [15:0] RST_LANE_CFG    = 16'hDC04;
    localparam logic [15:0] RST_POLARITY_EQ = 16'h000D;
    localparam int          GLOBAL_PD_BIT   = 15;
    localparam int          RSVD_HI_BIT     = 15;
    localparam int          SWING_MSB       = 14;
    localparam int          SWING_LSB       = 12;
    localparam int          LOS_BIT         = 11;
    localparam int          TX_EN_BIT       = 10;
    localparam int          TX_RATE_MSB     = 9;
    localparam int          TX_RATE_LSB     = 8;
    localparam int          DE_MSB          = 7;
    localparam int          DE_LSB          = 4;
    localparam int          RSVD_LO_BIT     = 3;
    localparam int          RX_EN_BIT       = 2;
    localparam int          RX_RATE_MSB     = 1;
    localparam int          RX_RATE_LSB     = 0;
    localparam logic [2:0]  SWING_RST       = 3'h5;
    localparam logic [3:0]  DE_RST          = 4'h0;
    localparam logic [1:0]  RATE_FULL       = 2'h0;
    localparam logic [1:0]  RATE_HALF       = 2'h1;
    localparam logic [1:0]  RATE_QUARTER    = 2'h2;
    localparam logic [1:0]  RATE_RSVD       = 2'h3;
    typedef enum logic [1:0] {
        LSLCR_MODE_4LANE,
        LSLCR_MODE_2LANE,
        LSLCR_MODE_1LANE,
        LSLCR_MODE_1G_KX
    } lslcr_mode_e;
endpackage

// ==== design/lslcr_regs.sv ====
// Low-speed lane configuration register bank behind the management register port.
//
// Functional notes
// - Swing code bits 14:12, reset 101, driven out.
// - Bit 11 enables loss-of-signal detection, reset 1.
// - Bit 10 transmit lane enable, reset 1.
// - Powerdown pin or global bit forces transmit lanes off.
// - Reduced-lane modes force upper transmit lanes off.
// - Bits 9:8 transmit lane rate, reset 00.
// - De-emphasis code bits 7:4, reset 0000.
// - Bit 2 receive lane enable, reset 1.
// - Powerdown pin or global bit forces receive lanes off.
// - Reduced-lane modes force upper receive lanes off.
// - Bits 1:0 receive lane rate, reset 00.
`timescale 1ns/1ns
module lslcr_regs #(
    parameter int LANES = lslcr_pkg::LANES
) (
    input  wire logic                         core_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         reg_wr_i,
    input  wire logic                         reg_rd_i,
    input  wire logic [4:0]                   reg_dev_i,
    input  wire logic [lslcr_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [lslcr_pkg::DATA_W-1:0] reg_wdata_i,
    output logic      [lslcr_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                              reg_rvalid_o,
    input  wire logic                         powerdown_pin_n_i,
    input  wire logic                         global_pd_i,
    input  wire lslcr_pkg::lslcr_mode_e       lane_mode_i,
    output logic      [2:0]                   tx_swing_code_o,
    output logic                              signal_loss_detect_en_o,
    output logic      [LANES-1:0]             tx_lane_enable_o,
    output logic      [1:0]                   tx_lane_rate_sel_o,
    output logic      [3:0]                   deemphasis_code_o,
    output logic      [LANES-1:0]             rx_lane_enable_o,
    output logic      [1:0]                   rx_lane_rate_sel_o,
    output logic      [lslcr_pkg::DATA_W-1:0] polarity_eq_o
);
    logic [lslcr_pkg::DATA_W-1:0] cfg_q;
    logic [lslcr_pkg::DATA_W-1:0] peq_q;
    logic [LANES-1:0]             mode_ok;
    logic                         pd_force;
    logic                         hit_dev;

    assign hit_dev  = (reg_dev_i == lslcr_pkg::DEV_ADDR);
    assign pd_force = !powerdown_pin_n_i || global_pd_i;

    // Configuration word; written whole, reserved bits stored as written.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_q <= lslcr_pkg::RST_LANE_CFG;
        end else if (reg_wr_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_LANE_CFG) begin
            cfg_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            peq_q <= lslcr_pkg::RST_POLARITY_EQ;
        end else if (reg_wr_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_POLARITY_EQ) begin
            peq_q <= reg_wdata_i;
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_LANE_CFG) begin
                reg_rdata_o <= cfg_q;
            end else if (reg_rd_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_POLARITY_EQ) begin
                reg_rdata_o <= peq_q;
            end else if (reg_rd_i) begin
                reg_rdata_o <= '0;
            end
        end
    end

    // Lanes allowed by the lane mode: lane 0 always, lane 1 only in 2- or 4-lane mode.
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            if (g == 0) begin : g_l0
                assign mode_ok[g] = 1'b1;
            end else if (g == 1) begin : g_l1
                assign mode_ok[g] = (lane_mode_i == lslcr_pkg::LSLCR_MODE_4LANE) ||
                                    (lane_mode_i == lslcr_pkg::LSLCR_MODE_2LANE);
            end else begin : g_hi
                assign mode_ok[g] = (lane_mode_i == lslcr_pkg::LSLCR_MODE_4LANE);
            end
        end
    endgenerate

    // Enables are combined in flip-flops so the outputs stay registered.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tx_lane_enable_o <= '0;
            rx_lane_enable_o <= '0;
        end else begin
            tx_lane_enable_o <= (pd_force || !cfg_q[lslcr_pkg::TX_EN_BIT]) ? '0 : mode_ok;
            rx_lane_enable_o <= (pd_force || !cfg_q[lslcr_pkg::RX_EN_BIT]) ? '0 : mode_ok;
        end
    end

    assign tx_swing_code_o         = cfg_q[lslcr_pkg::SWING_MSB:lslcr_pkg::SWING_LSB];
    assign signal_loss_detect_en_o = cfg_q[lslcr_pkg::LOS_BIT];
    assign tx_lane_rate_sel_o      = cfg_q[lslcr_pkg::TX_RATE_MSB:lslcr_pkg::TX_RATE_LSB];
    assign deemphasis_code_o       = cfg_q[lslcr_pkg::DE_MSB:lslcr_pkg::DE_LSB];
    assign rx_lane_rate_sel_o      = cfg_q[lslcr_pkg::RX_RATE_MSB:lslcr_pkg::RX_RATE_LSB];
    assign polarity_eq_o           = peq_q;

    logic cfg_wr;
    assign cfg_wr = reg_wr_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_LANE_CFG;

    sequence s_cfg_write;
        cfg_wr ##1 1'b1;
    endsequence

    a_swing_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |->
        tx_swing_code_o == $past(reg_wdata_i[lslcr_pkg::SWING_MSB:lslcr_pkg::SWING_LSB]))
        else $error("swing code did not follow write");
    a_swing_reset: assert property (@(posedge core_clk_i)
        $past(rst_i) |-> tx_swing_code_o == lslcr_pkg::SWING_RST)
        else $error("swing code reset value wrong");
    a_los_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |-> signal_loss_detect_en_o == $past(reg_wdata_i[lslcr_pkg::LOS_BIT]))
        else $error("loss detect enable did not follow write");
    a_tx_pd_force: assert property (@(posedge core_clk_i) disable iff (rst_i)
        pd_force |=> tx_lane_enable_o == '0)
        else $error("transmit lanes not forced off");
    a_tx_enable: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!pd_force && cfg_q[lslcr_pkg::TX_EN_BIT] && lane_mode_i == lslcr_pkg::LSLCR_MODE_4LANE)
        |=> tx_lane_enable_o == '1)
        else $error("transmit lanes not enabled");
    a_tx_mode_2l: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (lane_mode_i == lslcr_pkg::LSLCR_MODE_2LANE) |=> tx_lane_enable_o[3:2] == 2'h0)
        else $error("upper transmit lanes active in two-lane mode");
    a_tx_mode_1l: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (lane_mode_i inside {lslcr_pkg::LSLCR_MODE_1LANE, lslcr_pkg::LSLCR_MODE_1G_KX})
        |=> tx_lane_enable_o[3:1] == 3'h0)
        else $error("transmit lanes 3..1 active in one-lane mode");
    a_tx_rate_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |->
        tx_lane_rate_sel_o == $past(reg_wdata_i[lslcr_pkg::TX_RATE_MSB:lslcr_pkg::TX_RATE_LSB]))
        else $error("transmit rate did not follow write");
    a_de_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |-> deemphasis_code_o == $past(reg_wdata_i[lslcr_pkg::DE_MSB:lslcr_pkg::DE_LSB]))
        else $error("de-emphasis did not follow write");
    a_rx_disable: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !cfg_q[lslcr_pkg::RX_EN_BIT] |=> rx_lane_enable_o == '0)
        else $error("receive lanes on while disabled");
    a_rx_pd_force: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !powerdown_pin_n_i |=> rx_lane_enable_o == '0)
        else $error("receive lanes not forced off");
    a_rx_mode_1l: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (lane_mode_i == lslcr_pkg::LSLCR_MODE_1LANE) |=> rx_lane_enable_o[3:1] == 3'h0)
        else $error("receive lanes 3..1 active in one-lane mode");
    a_rx_rate_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |->
        rx_lane_rate_sel_o == $past(reg_wdata_i[lslcr_pkg::RX_RATE_MSB:lslcr_pkg::RX_RATE_LSB]))
        else $error("receive rate did not follow write");

    // Decodes used only by the assertions; they repeat the bus decode on purpose.
    logic peq_wr;
    logic cfg_rd;
    logic peq_rd;
    logic stray_wr;
    logic stray_rd;

    assign peq_wr   = reg_wr_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_POLARITY_EQ;
    assign cfg_rd   = reg_rd_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_LANE_CFG;
    assign peq_rd   = reg_rd_i && hit_dev && reg_addr_i == lslcr_pkg::OFS_POLARITY_EQ;
    assign stray_wr = reg_wr_i && !cfg_wr && !peq_wr;
    assign stray_rd = reg_rd_i && !cfg_rd && !peq_rd;

    sequence s_peq_write;
        peq_wr ##1 1'b1;
    endsequence

    sequence s_cfg_read;
        cfg_rd ##1 1'b1;
    endsequence

    sequence s_peq_read;
        peq_rd ##1 1'b1;
    endsequence

    sequence s_out_reset;
        rst_i ##1 1'b1;
    endsequence

    // Reset values, checked one cycle after any cycle with reset high.
    a_los_reset: assert property (@(posedge core_clk_i)
        s_out_reset |-> signal_loss_detect_en_o == lslcr_pkg::RST_LANE_CFG[lslcr_pkg::LOS_BIT])
        else $error("loss detect enable reset value wrong");
    a_tx_en_reset: assert property (@(posedge core_clk_i)
        s_out_reset |-> cfg_q[lslcr_pkg::TX_EN_BIT] == 1'b1)
        else $error("transmit enable bit reset value wrong");
    a_tx_rate_reset: assert property (@(posedge core_clk_i)
        s_out_reset |-> tx_lane_rate_sel_o == lslcr_pkg::RATE_FULL)
        else $error("transmit rate reset value wrong");
    a_de_reset: assert property (@(posedge core_clk_i)
        s_out_reset |-> deemphasis_code_o == lslcr_pkg::DE_RST)
        else $error("de-emphasis reset value wrong");
    a_rx_en_reset: assert property (@(posedge core_clk_i)
        s_out_reset |-> cfg_q[lslcr_pkg::RX_EN_BIT] == 1'b1)
        else $error("receive enable bit reset value wrong");
    a_rx_rate_reset: assert property (@(posedge core_clk_i)
        s_out_reset |-> rx_lane_rate_sel_o == lslcr_pkg::RATE_FULL)
        else $error("receive rate reset value wrong");
    a_peq_reset: assert property (@(posedge core_clk_i)
        s_out_reset |-> polarity_eq_o == lslcr_pkg::RST_POLARITY_EQ)
        else $error("polarity register reset value wrong");

    // Write path: whole-word stores, everything else leaves the registers alone.
    a_tx_en_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |-> cfg_q[lslcr_pkg::TX_EN_BIT] == $past(reg_wdata_i[lslcr_pkg::TX_EN_BIT]))
        else $error("transmit enable bit did not follow write");
    a_rx_en_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |-> cfg_q[lslcr_pkg::RX_EN_BIT] == $past(reg_wdata_i[lslcr_pkg::RX_EN_BIT]))
        else $error("receive enable bit did not follow write");
    a_cfg_whole: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_write |-> cfg_q == $past(reg_wdata_i))
        else $error("configuration word not stored whole");
    a_cfg_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !cfg_wr |=> $stable(cfg_q))
        else $error("configuration word changed without a write");
    a_peq_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_peq_write |-> polarity_eq_o == $past(reg_wdata_i))
        else $error("polarity register did not follow write");
    a_peq_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !peq_wr |=> $stable(peq_q))
        else $error("polarity register changed without a write");
    a_stray_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        stray_wr |=> $stable(cfg_q) && $stable(peq_q))
        else $error("unmapped write changed a register");

    // Read path: one-cycle valid pulse, data held until the next read.
    a_rvalid_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
        reg_rd_i |=> reg_rvalid_o)
        else $error("read valid missing after read strobe");
    a_rvalid_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without read strobe");
    a_cfg_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_cfg_read |-> reg_rdata_o == $past(cfg_q))
        else $error("configuration read data wrong");
    a_peq_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_peq_read |-> reg_rdata_o == $past(peq_q))
        else $error("polarity read data wrong");
    a_stray_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
        stray_rd |=> reg_rdata_o == '0)
        else $error("unmapped read did not return zero");
    a_rdata_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    // Lane enables: forcing terms and the lanes each mode keeps alive.
    a_tx_disable: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !cfg_q[lslcr_pkg::TX_EN_BIT] |=> tx_lane_enable_o == '0)
        else $error("transmit lanes on while disabled");
    a_tx_pin_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !powerdown_pin_n_i |=> tx_lane_enable_o == '0)
        else $error("transmit lanes on while pin powered down");
    a_tx_gpd_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        global_pd_i |=> tx_lane_enable_o == '0)
        else $error("transmit lanes on under global power-down");
    a_tx_lane0: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!pd_force && cfg_q[lslcr_pkg::TX_EN_BIT]) |=> tx_lane_enable_o[0])
        else $error("transmit lane 0 off while enabled");
    a_tx_2l_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!pd_force && cfg_q[lslcr_pkg::TX_EN_BIT] && lane_mode_i == lslcr_pkg::LSLCR_MODE_2LANE)
        |=> tx_lane_enable_o[1:0] == 2'h3)
        else $error("transmit lanes 1..0 off in two-lane mode");
    a_rx_enable: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!pd_force && cfg_q[lslcr_pkg::RX_EN_BIT] && lane_mode_i == lslcr_pkg::LSLCR_MODE_4LANE)
        |=> rx_lane_enable_o == '1)
        else $error("receive lanes not enabled");
    a_rx_gpd_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
        global_pd_i |=> rx_lane_enable_o == '0)
        else $error("receive lanes on under global power-down");
    a_rx_mode_2l: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (lane_mode_i == lslcr_pkg::LSLCR_MODE_2LANE) |=> rx_lane_enable_o[3:2] == 2'h0)
        else $error("upper receive lanes active in two-lane mode");
    a_rx_mode_kx: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (lane_mode_i == lslcr_pkg::LSLCR_MODE_1G_KX) |=> rx_lane_enable_o[3:1] == 3'h0)
        else $error("receive lanes 3..1 active in 1G mode");
    a_rx_lane0: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!pd_force && cfg_q[lslcr_pkg::RX_EN_BIT]) |=> rx_lane_enable_o[0])
        else $error("receive lane 0 off while enabled");
    a_rx_2l_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!pd_force && cfg_q[lslcr_pkg::RX_EN_BIT] && lane_mode_i == lslcr_pkg::LSLCR_MODE_2LANE)
        |=> rx_lane_enable_o[1:0] == 2'h3)
        else $error("receive lanes 1..0 off in two-lane mode");
endmodule

// ==== dv/lslcr_host.sv ====
// Management host model issuing whole-word register writes and reads.
`timescale 1ns/1ns
module lslcr_host (
    input  wire logic        core_clk_i,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        reg_rvalid_i,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic [4:0]       reg_dev_o,
    output logic [15:0]      reg_addr_o,
    output logic [15:0]      reg_wdata_o
);
    initial begin
        {reg_wr_o, reg_rd_o, reg_dev_o, reg_addr_o, reg_wdata_o} = '0;
    end
    task automatic drive(input logic w, input logic [4:0] dv, input logic [15:0] a,
                         input logic [15:0] d);
        @(negedge core_clk_i);
        {reg_wr_o, reg_rd_o, reg_dev_o, reg_addr_o, reg_wdata_o} = {w, !w, dv, a, d};
        @(negedge core_clk_i);
        // Released lines show a changed pattern so stale values cannot pass.
        {reg_wr_o, reg_rd_o, reg_dev_o, reg_addr_o, reg_wdata_o} = {2'b00, ~dv, ~a, ~d};
    endtask
    task automatic rd(input logic [4:0] dv, input logic [15:0] a, output logic [15:0] d,
                      output logic ok);
        drive(1'b0, dv, a, 16'h0000);
        ok = (reg_rvalid_i === 1'b1);
        d = reg_rdata_i;
    endtask
endmodule

// ==== dv/lslcr_regs_tb_top.sv ====
// Self-checking bench for the lane configuration register bank.
`timescale 1ns/1ns
`define CHK(a, b) \
    begin \
        check_count++; \
        if ((a) !== (b)) begin \
            errors++; \
            $display("ERROR %0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module lslcr_regs_tb_top;
    logic        core_clk_i  = 1'b0;
    logic        rst_i       = 1'b1;
    logic        pdn         = 1'b1;
    logic        gpd         = 1'b0;
    logic [1:0]  mode        = 2'h0;
    logic [31:0] seed        = 32'hBA6ABCFF;
    int          errors      = 0;
    int          check_count = 0;
    logic        wr, rd, rvalid, los, ok;
    logic [4:0]  dev;
    logic [15:0] addr, wdata, rdata, peq, rv, cfg, d;
    logic [3:0]  tx_en, rx_en, de;
    logic [2:0]  swing;
    logic [1:0]  tx_rate, rx_rate;
    lslcr_host lslcr_host_i (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_dev_o(dev), .reg_addr_o(addr), .reg_wdata_o(wdata));
    lslcr_regs lslcr_regs_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_dev_i(dev), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .powerdown_pin_n_i(pdn), .global_pd_i(gpd),
        .lane_mode_i(lslcr_pkg::lslcr_mode_e'(mode)), .tx_swing_code_o(swing),
        .signal_loss_detect_en_o(los), .tx_lane_enable_o(tx_en), .tx_lane_rate_sel_o(tx_rate),
        .deemphasis_code_o(de), .rx_lane_enable_o(rx_en), .rx_lane_rate_sel_o(rx_rate),
        .polarity_eq_o(peq));
    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [3:0] en_exp(input logic en);
        if (!en || !pdn || gpd) return 4'h0;
        if (mode == 2'h1) return 4'h3;
        if (mode[1]) return 4'h1;
        return 4'hF;
    endfunction
    task automatic check_cfg;
        `CHK(swing, cfg[14:12])
        `CHK(los, cfg[11])
        `CHK(tx_rate, cfg[9:8])
        `CHK(de, cfg[7:4])
        `CHK(rx_rate, cfg[1:0])
        `CHK(tx_en, en_exp(cfg[10]))
        `CHK(rx_en, en_exp(cfg[2]))
        lslcr_host_i.rd(5'h1E, 16'h0007, rv, ok);
        `CHK({ok, rv}, {1'b1, cfg})
    endtask
    task automatic close_out;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge core_clk_i);
        rst_i = 1'b0;
        cfg = 16'hDC04;
        repeat (2) @(negedge core_clk_i);
        check_cfg();
        `CHK(peq, 16'h000D)
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            d = seed[15:0];
            // Legal rates only, reserved bits written back as read.
            d[9:8] = 2'(i % 3);
            d[1:0] = 2'((i + 1) % 3);
            {d[15], d[3]} = {cfg[15], cfg[3]};
            mode = 2'(i % 4);
            pdn = (i % 5 != 4);
            gpd = (i % 7 == 3);
            lslcr_host_i.drive(1'b1, 5'h1E, 16'h0007, d);
            cfg = d;
            lslcr_host_i.drive(1'b1, 5'h1F, 16'h0007, ~d);
            lslcr_host_i.drive(1'b1, 5'h1E, 16'h0009, ~d);
            check_cfg();
            lslcr_host_i.drive(1'b1, 5'h1E, 16'h0008, seed[31:16]);
            `CHK(peq, seed[31:16])
            lslcr_host_i.rd(5'h1E, 16'h0009, rv, ok);
            `CHK({ok, rv}, 17'h10000)
        end
        close_out();
    end
endmodule
